// ==== design/quota_retry_pkg.sv ====
// ****************************************************************
// shared constants for fault retry and charge quota
// ****************************************************************
package quota_retry_pkg;
  // register byte offsets, multi-byte values most significant first
  localparam logic [7:0]  RECOVERY_CFG_OFS = 8'h15;
  localparam logic [7:0]  P1_TOTAL_OFS     = 8'h16;
  localparam logic [7:0]  P2_TOTAL_OFS     = 8'h1A;
  localparam logic [7:0]  P1_LIMIT_OFS     = 8'h1E;
  localparam logic [7:0]  P2_LIMIT_OFS     = 8'h20;
  localparam logic [7:0]  QUOTA_CFG_OFS    = 8'h22;
  // values after reset
  localparam logic [7:0]  RECOVERY_CFG_RST = 8'h2A;
  localparam logic [7:0]  QUOTA_CFG_RST    = 8'h11;
  localparam logic [15:0] LIMIT_RST        = 16'hFFFF;
  // recovery config field positions
  localparam int          LATCH_BIT        = 7;
  localparam int          RETRY_LSB        = 4;
  localparam int          TEST_LSB         = 2;
  localparam int          THR_LSB          = 0;
  // quota config: port p sits at bit 4*p
  localparam int          PORT_FIELD_STEP  = 4;
  localparam int          QEN_BIT          = 3;
  localparam int          QCLR_BIT         = 2;
  localparam int          QRESP_LSB        = 0;
  // widths and scaling
  localparam int          COUNT_W          = 26;
  localparam int          LIMIT_W          = 16;
  localparam int          STEP_W           = 16;
  localparam int          COUNT_PAD        = 6;
  localparam int          LIMIT_SHIFT      = 10;
  // timing
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          MS_NS            = 1000000;
  localparam int          CYCLES_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int          MS_DIV_W         = 17;
  localparam int          RETRY_BASE_MS    = 15;
  localparam int          RETRY_STEP_MS    = 5;
  localparam int          TEST_BASE_MS     = 10;
  localparam int          TEST_STEP_MS     = 5;
  localparam int          UPDATE_PERIOD_MS = 1000;
  // quota response codes
  localparam logic [1:0]  RESP_REPORT      = 2'h0;
  localparam logic [1:0]  RESP_DISCONNECT  = 2'h1;
  localparam logic [1:0]  RESP_SLEEP       = 2'h2;
  localparam logic [1:0]  RESP_IGNORE      = 2'h3;
  // fault handling states
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_WAIT = 2'b01,
    ST_TEST = 2'b10,
    ST_HOLD = 2'b11
  } fault_state_type;
endpackage

// ==== design/charge_accumulator.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// one port: charge counter and quota compare
// ****************************************************************
module charge_accumulator
  import quota_retry_pkg::*;
(
  input  wire logic                               i_mclk,
  input  wire logic                               i_rst_n,
  input  wire logic                               i_update,
  input  wire logic                               i_enable,
  input  wire logic                               i_clear,
  input  wire logic [quota_retry_pkg::STEP_W-1:0]  i_step,
  input  wire logic [quota_retry_pkg::LIMIT_W-1:0] i_limit,
  output logic      [quota_retry_pkg::COUNT_W-1:0] o_count,
  output logic                                    o_hit
);
  import quota_retry_pkg::*;

  logic [COUNT_W:0]   sum;       // one spare bit for saturation
  logic [COUNT_W-1:0] count_next;

  // saturating add of this second's charge
  always_comb begin
    sum        = {1'b0, o_count} + {{(COUNT_W+1-STEP_W){1'b0}}, i_step};
    count_next = sum[COUNT_W] ? {COUNT_W{1'b1}} : sum[COUNT_W-1:0];
  end

  // ****************************************************************
  // counter: clear, or add once per update, otherwise hold
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_count <= '0;
    end else if (i_clear || !i_enable) begin
      o_count <= '0;
    end else if (i_update) begin
      o_count <= count_next;
    end
  end

  // ****************************************************************
  // quota flag: set on an update at or past the limit, clear or disable wins
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_hit <= 1'b0;
    end else if (i_update && i_enable && !i_clear &&
                 count_next[COUNT_W-1:LIMIT_SHIFT] >= i_limit) begin
      o_hit <= 1'b1;
    end else if (i_clear || !i_enable) begin
      o_hit <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_clear_zero;
    (i_clear || !i_enable) |=> (o_count == '0);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("count not cleared");

  property p_hold_between;
    (!i_update && i_enable && !i_clear) |=> $stable(o_count);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("count moved");

  property p_hit_cause;
    $rose(o_hit) |-> $past(i_update) &&
      (o_count[COUNT_W-1:LIMIT_SHIFT] >= $past(i_limit));
  endproperty
  a_hit_cause: assert property (p_hit_cause) else $error("bad quota hit");

  c_hit: cover property ($rose(o_hit));
endmodule
`default_nettype wire

// ==== design/fault_retry_quota.sv ====
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - latch mode: hold error until software clears
// - retry mode: recover automatically, no software
// - retry delay 15 to 50 ms, 5 ms steps
// - test interval 10, 15, 20, 25 ms
// - short clear needs voltage above selected threshold
// - test: low current, switch on, recheck
// - 26-bit count in upper word bits
// - count clears only on clear or disable
// - count kept outside active, resumes later
// - count updates each second, active only
// - counts retained through sleep
// - count at or above limit sets flag
// - 16-bit limit, resets to all ones
// - response: report, disconnect, sleep, ignore
module fault_retry_quota
  import quota_retry_pkg::*;
#(
  parameter int CYCLES_PER_MS_P = quota_retry_pkg::CYCLES_PER_MS
)(
  input  wire logic                              i_mclk,
  input  wire logic                              i_rst_n,
  input  wire logic [7:0]                        i_reg_addr,
  input  wire logic                              i_reg_wr,
  input  wire logic [7:0]                        i_reg_wdata,
  input  wire logic                              i_reg_rd,
  output logic      [7:0]                        o_reg_rdata,
  input  wire logic                              i_fault,
  input  wire logic                              i_vbus_above_test,
  input  wire logic                              i_err_clear,
  input  wire logic                              i_active,
  input  wire logic [quota_retry_pkg::STEP_W-1:0] i_port1_charge_step,
  input  wire logic [quota_retry_pkg::STEP_W-1:0] i_port2_charge_step,
  output logic                                   o_err_flag,
  output logic                                   o_test_current,
  output logic                                   o_switch_on,
  output logic      [1:0]                        o_short_clear_threshold_select,
  output logic                                   o_port1_quota_hit,
  output logic                                   o_port2_quota_hit,
  output logic                                   o_port1_disconnect,
  output logic                                   o_port2_disconnect,
  output logic                                   o_sleep_request
);
  import quota_retry_pkg::*;

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [7:0]          recovery_cfg_reg;       // fault recovery config
  logic [7:0]          quota_cfg_reg;          // per-port enable, clear, response
  logic [LIMIT_W-1:0]  limit_reg [2];          // quota limits
  logic [31:0]         shadow_reg [2];         // read snapshot of counts
  logic [1:0]          sync1_reg;              // first sync stage
  logic [1:0]          sync2_reg;              // fault, vbus ok
  logic [MS_DIV_W-1:0] ms_div_reg;             // cycles within a ms
  logic                ms_tick;                // one-cycle ms enable
  logic [9:0]          sec_div_reg;            // ms within a second
  logic                sec_tick;               // one-cycle update enable
  fault_state_type     state_reg;              // fault handling state
  logic [5:0]          timer_reg;              // ms in current state
  logic [5:0]          retry_ms;               // selected retry delay
  logic [5:0]          test_ms;                // selected test interval
  logic [COUNT_W-1:0]  count [2];              // live counts
  logic [1:0]          hit;                    // quota flags
  logic [STEP_W-1:0]   step [2];               // per-second charge
  logic [1:0]          resp [2];               // per-port response
  logic                fault_s;                // synced fault
  logic                vbus_ok_s;              // synced comparator
  logic [7:0]          rdata_next;             // read mux

  assign fault_s   = sync2_reg[0];
  assign vbus_ok_s = sync2_reg[1];
  assign step[0]   = i_port1_charge_step;
  assign step[1]   = i_port2_charge_step;
  assign retry_ms  = 6'(RETRY_BASE_MS + RETRY_STEP_MS * int'(recovery_cfg_reg[RETRY_LSB +: 3]));
  assign test_ms   = 6'(TEST_BASE_MS + TEST_STEP_MS * int'(recovery_cfg_reg[TEST_LSB +: 2]));
  assign ms_tick   = (ms_div_reg == MS_DIV_W'(CYCLES_PER_MS_P - 1));
  assign sec_tick  = ms_tick && (sec_div_reg == 10'(UPDATE_PERIOD_MS - 1));

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end else begin
      sync1_reg <= {i_vbus_above_test, i_fault};
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************************************
  // dividers: ms enable, then one-second update enable
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ms_div_reg <= '0;
    end else if (ms_tick) begin
      ms_div_reg <= '0;
    end else begin
      ms_div_reg <= ms_div_reg + 1'b1;
    end
  end

  // second counter only runs in the active state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !i_active) begin
      sec_div_reg <= '0;
    end else if (sec_tick) begin
      sec_div_reg <= '0;
    end else if (ms_tick) begin
      sec_div_reg <= sec_div_reg + 1'b1;
    end
  end

  // ****************************************************************
  // register writes, single byte, msb at lowest address
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      recovery_cfg_reg <= RECOVERY_CFG_RST;
      quota_cfg_reg    <= QUOTA_CFG_RST;
      limit_reg[0]     <= LIMIT_RST;
      limit_reg[1]     <= LIMIT_RST;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        RECOVERY_CFG_OFS:     recovery_cfg_reg    <= i_reg_wdata;
        QUOTA_CFG_OFS:        quota_cfg_reg       <= i_reg_wdata;
        P1_LIMIT_OFS:         limit_reg[0][15:8]  <= i_reg_wdata;
        P1_LIMIT_OFS + 8'h01: limit_reg[0][7:0]   <= i_reg_wdata;
        P2_LIMIT_OFS:         limit_reg[1][15:8]  <= i_reg_wdata;
        P2_LIMIT_OFS + 8'h01: limit_reg[1][7:0]   <= i_reg_wdata;
        default: ;                                         // others read-only
      endcase
    end
  end

  // ****************************************************************
  // fault handling state machine
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_reg <= ST_RUN;
      timer_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          timer_reg <= '0;
          if (fault_s) begin
            state_reg <= recovery_cfg_reg[LATCH_BIT] ? ST_HOLD : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ms_tick && timer_reg == retry_ms - 6'h01) begin
            state_reg <= ST_TEST;
            timer_reg <= '0;
          end else if (ms_tick) begin
            timer_reg <= timer_reg + 6'h01;
          end
        end
        ST_TEST: begin
          if (ms_tick && timer_reg == test_ms - 6'h01) begin
            state_reg <= vbus_ok_s ? ST_RUN : ST_WAIT;
            timer_reg <= '0;
          end else if (ms_tick) begin
            timer_reg <= timer_reg + 6'h01;
          end
        end
        ST_HOLD: begin
          if (i_err_clear) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // fault outputs follow the state, threshold select the config, one cycle later
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_err_flag     <= 1'b0;
      o_test_current <= 1'b0;
      o_switch_on    <= 1'b1;
      o_short_clear_threshold_select <= RECOVERY_CFG_RST[THR_LSB +: 2];
    end else begin
      o_err_flag     <= (state_reg != ST_RUN);
      o_test_current <= (state_reg == ST_TEST);
      o_switch_on    <= (state_reg == ST_RUN) || (state_reg == ST_TEST);
      o_short_clear_threshold_select <= recovery_cfg_reg[THR_LSB +: 2];
    end
  end

  // ****************************************************************
  // per-port accumulators, independent of each other
  // ****************************************************************
  for (genvar p = 0; p < 2; p++) begin : g_port
    assign resp[p] = quota_cfg_reg[p*PORT_FIELD_STEP + QRESP_LSB +: 2];
    charge_accumulator u_acc (
      .i_mclk   (i_mclk),
      .i_rst_n  (i_rst_n),
      .i_update (sec_tick && i_active),
      .i_enable (quota_cfg_reg[p*PORT_FIELD_STEP + QEN_BIT]),
      .i_clear  (quota_cfg_reg[p*PORT_FIELD_STEP + QCLR_BIT]),
      .i_step   (step[p]),
      .i_limit  (limit_reg[p]),
      .o_count  (count[p]),
      .o_hit    (hit[p])
    );
  end
  assign o_port1_quota_hit = hit[0];
  assign o_port2_quota_hit = hit[1];

  // quota response decode
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_port1_disconnect <= 1'b0;
      o_port2_disconnect <= 1'b0;
      o_sleep_request    <= 1'b0;
    end else begin
      o_port1_disconnect <= hit[0] && (resp[0] == RESP_DISCONNECT || resp[0] == RESP_SLEEP);
      o_port2_disconnect <= hit[1] && (resp[1] == RESP_DISCONNECT || resp[1] == RESP_SLEEP);
      o_sleep_request    <= (hit[0] && resp[0] == RESP_SLEEP) ||
                            (hit[1] && resp[1] == RESP_SLEEP);
    end
  end

  // ****************************************************************
  // reads: msb byte read snapshots the whole count
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      shadow_reg[0] <= '0;
      shadow_reg[1] <= '0;
    end else if (i_reg_rd && i_reg_addr == P1_TOTAL_OFS) begin
      shadow_reg[0] <= {count[0], {COUNT_PAD{1'b0}}};
    end else if (i_reg_rd && i_reg_addr == P2_TOTAL_OFS) begin
      shadow_reg[1] <= {count[1], {COUNT_PAD{1'b0}}};
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    unique case (i_reg_addr)
      RECOVERY_CFG_OFS:     rdata_next = recovery_cfg_reg;
      QUOTA_CFG_OFS:        rdata_next = quota_cfg_reg;
      P1_TOTAL_OFS:         rdata_next = count[0][COUNT_W-1 -: 8];
      P1_TOTAL_OFS + 8'h01: rdata_next = shadow_reg[0][23:16];
      P1_TOTAL_OFS + 8'h02: rdata_next = shadow_reg[0][15:8];
      P1_TOTAL_OFS + 8'h03: rdata_next = shadow_reg[0][7:0];
      P2_TOTAL_OFS:         rdata_next = count[1][COUNT_W-1 -: 8];
      P2_TOTAL_OFS + 8'h01: rdata_next = shadow_reg[1][23:16];
      P2_TOTAL_OFS + 8'h02: rdata_next = shadow_reg[1][15:8];
      P2_TOTAL_OFS + 8'h03: rdata_next = shadow_reg[1][7:0];
      P1_LIMIT_OFS:         rdata_next = limit_reg[0][15:8];
      P1_LIMIT_OFS + 8'h01: rdata_next = limit_reg[0][7:0];
      P2_LIMIT_OFS:         rdata_next = limit_reg[1][15:8];
      P2_LIMIT_OFS + 8'h01: rdata_next = limit_reg[1][7:0];
      default:              rdata_next = 8'h00;
    endcase
  end

  // registered read data
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_latch_hold;
    (state_reg == ST_HOLD && !i_err_clear) |=> (state_reg == ST_HOLD);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched error left");

  property p_auto_retry;
    (state_reg == ST_RUN && fault_s && !recovery_cfg_reg[LATCH_BIT]) |=> (state_reg == ST_WAIT);
  endproperty
  a_auto_retry: assert property (p_auto_retry) else $error("no auto retry");

  property p_retry_delay;
    (state_reg == ST_WAIT && ms_tick && timer_reg == retry_ms - 6'h01) |=> (state_reg == ST_TEST);
  endproperty
  a_retry_delay: assert property (p_retry_delay) else $error("retry delay wrong");

  property p_test_early;
    (state_reg == ST_TEST && !(ms_tick && timer_reg == test_ms - 6'h01)) |=> (state_reg == ST_TEST);
  endproperty
  a_test_early: assert property (p_test_early) else $error("test ended early");

  property p_short_clear;
    (state_reg == ST_TEST && ms_tick && timer_reg == test_ms - 6'h01) |=>
      (state_reg == ($past(vbus_ok_s) ? ST_RUN : ST_WAIT));
  endproperty
  a_short_clear: assert property (p_short_clear) else $error("bad test verdict");

  property p_test_outputs;
    (state_reg == ST_TEST) |=> (o_test_current && o_switch_on && o_err_flag);
  endproperty
  a_test_outputs: assert property (p_test_outputs) else $error("test drive wrong");

  property p_no_update_idle;
    !i_active |=> !sec_tick;
  endproperty
  a_no_update_idle: assert property (p_no_update_idle) else $error("update while idle");

  property p_sleep_resp;
    (hit[0] && resp[0] == RESP_SLEEP) |=> (o_sleep_request && o_port1_disconnect);
  endproperty
  a_sleep_resp: assert property (p_sleep_resp) else $error("sleep response missing");

  property p_limit_reset;
    $rose(i_rst_n) |-> (limit_reg[0] == LIMIT_RST && limit_reg[1] == LIMIT_RST);
  endproperty
  a_limit_reset: assert property (p_limit_reset) else $error("limit reset wrong");

  c_retry_ok: cover property (state_reg == ST_TEST ##1 state_reg == ST_RUN);
  c_retry_fail: cover property (state_reg == ST_TEST ##1 state_reg == ST_WAIT);
  c_latched: cover property (state_reg == ST_HOLD ##1 state_reg == ST_RUN);
endmodule
`default_nettype wire

// ==== verification/charge_drain_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// far side: portable load that can short the port on command
// ****************************************************************
module charge_drain_model #(
  parameter logic [15:0] STEP1 = 16'h0400,
  parameter logic [15:0] STEP2 = 16'h0003
)(
  input  wire logic        i_mclk,
  input  wire logic        i_short,
  input  wire logic        i_switch_on,
  output logic             o_fault,
  output logic             o_vbus_ok,
  output logic [15:0]      o_step1,
  output logic [15:0]      o_step2
);
  // a short trips only while the switch feeds it, and then pulls vbus low
  always_ff @(posedge i_mclk) begin
    o_fault   <= i_short & i_switch_on;
    o_vbus_ok <= i_switch_on & ~i_short;
    o_step1   <= STEP1;
    o_step2   <= STEP2;
  end
endmodule
`default_nettype wire

// ==== verification/fault_retry_quota_test.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// self-checking bench for retry timing and charge quota
// ****************************************************************
module fault_retry_quota_test;
  import quota_retry_pkg::*;
  logic        i_mclk, i_rst_n, rd, wr, errc, act, shrt;
  logic [7:0]  addr, wd, rdat;
  logic        flt, vok, err, tcur, sw, h1, h2, d1, d2, slp;
  logic [1:0]  thr;
  logic [15:0] s1, s2;
  int          fails, cmp_count;
  // ms shortened to 10 cycles, so one second is 10000 cycles
  fault_retry_quota #(.CYCLES_PER_MS_P(10)) i_fault_retry_quota (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd), .i_reg_rd(rd),
    .o_reg_rdata(rdat), .i_fault(flt), .i_vbus_above_test(vok), .i_err_clear(errc),
    .i_active(act), .i_port1_charge_step(s1), .i_port2_charge_step(s2), .o_err_flag(err),
    .o_test_current(tcur), .o_switch_on(sw), .o_short_clear_threshold_select(thr),
    .o_port1_quota_hit(h1), .o_port2_quota_hit(h2), .o_port1_disconnect(d1),
    .o_port2_disconnect(d2), .o_sleep_request(slp));
  charge_drain_model i_charge_drain_model (.i_mclk(i_mclk), .i_short(shrt),
    .i_switch_on(sw), .o_fault(flt), .o_vbus_ok(vok), .o_step1(s1), .o_step2(s2));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1 check(rdat, e);
  endtask
  // byte 0 first, so the snapshot covers all four bytes
  task rd_count(input logic [7:0] ofs, input logic [31:0] e);
    for (int b = 0; b < 4; b++) begin
      rd_chk(ofs + 8'(b), e[31-8*b -: 8]);
    end
  endtask
  task automatic wait_sig(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 12000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (n >= 12000) begin
      fails++;
      $display("wrong value at %0t: wait limit reached", $time);
    end
  endtask
  task reset_chk;
    rd_chk(RECOVERY_CFG_OFS, RECOVERY_CFG_RST);
    rd_chk(QUOTA_CFG_OFS, QUOTA_CFG_RST);
    for (int a = 0; a < 4; a++) begin
      rd_chk(P1_LIMIT_OFS + 8'(a), 8'hFF);
    end
    rd_count(P1_TOTAL_OFS, 32'h0);
    rd_count(P2_TOTAL_OFS, 32'h0);
    rd_chk(8'h30, 8'h00);
    wr_reg(P2_LIMIT_OFS, 8'h12);
    rd_chk(P2_LIMIT_OFS, 8'h12);
    rd_chk(P1_LIMIT_OFS, 8'hFF);
    wr_reg(P2_LIMIT_OFS, 8'hFF);
    check({6'h0, thr}, 8'h02);
  endtask
  // short held through one test, removed before the next
  task retry_chk(input logic [7:0] cfg, input int r, input int t);
    int n;
    wr_reg(RECOVERY_CFG_OFS, cfg);
    @(posedge i_mclk);
    #1 check({6'h0, thr}, {6'h0, cfg[1:0]});
    @(posedge i_mclk);
    shrt <= 1'b1;
    wait_sig(err, 1'b1, n);
    wait_sig(tcur, 1'b1, n);
    check({7'h0, n >= r*10-10 && n <= r*10+5}, 8'h01);
    wait_sig(tcur, 1'b0, n);
    check({7'h0, n >= t*10-10 && n <= t*10+5}, 8'h01);
    check({7'h0, err}, 8'h01);
    @(posedge i_mclk);
    shrt <= 1'b0;
    wait_sig(tcur, 1'b1, n);
    check({7'h0, sw}, 8'h01);
    wait_sig(err, 1'b0, n);
    check({7'h0, n >= t*10-10 && n <= t*10+5}, 8'h01);
    check({6'h0, tcur, sw}, 8'h01);
  endtask
  task latch_chk;
    int n;
    wr_reg(RECOVERY_CFG_OFS, 8'hAA);
    @(posedge i_mclk);
    shrt <= 1'b1;
    wait_sig(err, 1'b1, n);
    @(posedge i_mclk);
    shrt <= 1'b0;
    repeat (700) @(posedge i_mclk);
    #1 check({6'h0, err, tcur}, 8'h02);
    @(posedge i_mclk);
    errc <= 1'b1;
    @(posedge i_mclk);
    errc <= 1'b0;
    wait_sig(err, 1'b0, n);
    check({6'h0, n < 5, sw}, 8'h03);
  endtask
  // every response code on port 1, port 2 disabled meanwhile
  task quota_resp;
    int n;
    wr_reg(P1_LIMIT_OFS, 8'h00);
    wr_reg(P1_LIMIT_OFS + 8'h01, 8'h01);
    for (int r = 0; r < 4; r++) begin
      wr_reg(QUOTA_CFG_OFS, 8'h04);
      rd_count(P1_TOTAL_OFS, 32'h0);
      wr_reg(QUOTA_CFG_OFS, 8'h08 | 8'(r));
      wait_sig(h1, 1'b1, n);
      repeat (2) @(posedge i_mclk);
      #1 check({3'h0, n <= 10010, h1, d1, slp, h2}, {3'h0, 2'h3, r == 1 || r == 2, r == 2, 1'b0});
    end
  endtask
  task quota_hold;
    int n;
    wr_reg(QUOTA_CFG_OFS, 8'h44);
    wr_reg(QUOTA_CFG_OFS, 8'h88);
    wait_sig(h1, 1'b1, n);
    repeat (2) @(posedge i_mclk);
    rd_count(P1_TOTAL_OFS, 32'h0001_0000);
    rd_count(P2_TOTAL_OFS, 32'h0000_00C0);
    check({6'h0, h2, d1}, 8'h00);
    check({6'h0, d2, slp}, 8'h00);
    wr_reg(P1_TOTAL_OFS, 8'hFF);
    @(posedge i_mclk);
    act <= 1'b0;
    repeat (15000) @(posedge i_mclk);
    rd_count(P1_TOTAL_OFS, 32'h0001_0000);
    @(posedge i_mclk);
    act <= 1'b1;
    repeat (10020) @(posedge i_mclk);
    rd_count(P1_TOTAL_OFS, 32'h0002_0000);
    rd_count(P2_TOTAL_OFS, 32'h0000_0180);
    wr_reg(QUOTA_CFG_OFS, 8'h8C);
    rd_count(P1_TOTAL_OFS, 32'h0);
    check({7'h0, h1}, 8'h00);
  endtask
  task complete_run;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    {rd, wr, errc, shrt, addr, wd} <= '0;
    i_rst_n <= 1'b0;
    act <= 1'b1;
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    reset_chk;
    retry_chk(8'h2A, 25, 20);
    retry_chk(8'h7F, 50, 25);
    retry_chk(8'h00, 15, 10);
    latch_chk;
    quota_resp;
    quota_hold;
    complete_run;
  end
  // watchdog past the roughly 80000 cycles of the sequence, under 100000
  initial begin
    #950000;
    fails++;
    complete_run;
  end
endmodule
`default_nettype wire
